//--- rtl/smkseq_top.sv
// Purpose: Timing and alarm sequencer of an ionization smoke detector.
// Assumes: Comparator and test inputs are synchronous to CORE_CLK.
// Notes: Registers are reached over AXI4-Lite; TICK_CYC may be shortened for simulation.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "smkseq_params.svh"

module smkseq_top
    import smkseq_pkg::*;
#(
    parameter int TICK_CYC = `SMK_TICK_CYC
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        SMOKE_CMP,
    input  wire logic        BAT_CMP,
    input  wire logic        TEST_N,
    output wire logic        HORN,
    output wire logic        HORN_EN,
    output wire logic        LED,
    output wire logic        STROBE,
    output wire logic        SMOKE_STAT,
    output wire logic        BAT_STAT,
    output wire logic        SENS_BOOST,
    output wire logic        IRQ,
    input  wire logic        S_AXI_AWVALID,
    output wire logic        S_AXI_AWREADY,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_WVALID,
    output wire logic        S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    output wire logic        S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output wire logic [1:0]  S_AXI_BRESP,
    input  wire logic        S_AXI_ARVALID,
    output wire logic        S_AXI_ARREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    output wire logic        S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output wire logic [31:0] S_AXI_RDATA,
    output wire logic [1:0]  S_AXI_RRESP
);

    localparam logic [19:0] TICK_LIM = 20'(TICK_CYC - 1);
    localparam logic [10:0] SLOW_LIM = 11'(`SMK_SLOW_MS / `SMK_TICK_MS - 1);
    localparam logic [10:0] FAST_LIM = 11'(`SMK_FAST_MS / `SMK_TICK_MS - 1);
    localparam logic [7:0]  ON_LIM   = 8'(`SMK_HORN_ON_MS / `SMK_TICK_MS - 1);
    localparam logic [7:0]  OFF_LIM  = 8'(`SMK_HORN_OFF_MS / `SMK_TICK_MS - 1);
    localparam logic [3:0]  STR_LIM  = 4'(`SMK_STROBE_MS / `SMK_TICK_MS - 1);
    localparam logic [3:0]  LED_LIM  = 4'(`SMK_LED_MS / `SMK_TICK_MS - 1);
    localparam logic [4:0]  BAT_LIM  = 5'(`SMK_BAT_CYCLES - 1);
    localparam logic [4:0]  LEDF_LIM = 5'(`SMK_LED_FAST_CYCLES - 1);

    localparam smkseq_state_t RST_S = '{
        horn:    HRN_IDLE,
        ctrl_en: `SMK_CTRL_RST,
        irq_msk: `SMK_IMSK_RST,
        default: '0
    };

    smkseq_state_t q;
    smkseq_state_t d;

    logic        tick;
    logic        fast;
    logic        busy;
    logic        per_wrap;
    logic        led_go;
    logic [10:0] per_lim;
    logic [4:0]  cyc_lim;
    logic [2:0]  irq_ev;
    logic [2:0]  irq_clr;
    logic [31:0] stat_word;

    assign S_AXI_AWREADY = !q.aw_v && !q.bvalid;
    assign S_AXI_WREADY  = !q.w_v && !q.bvalid;
    assign S_AXI_ARREADY = !q.rvalid;
    assign S_AXI_BVALID  = q.bvalid;
    assign S_AXI_BRESP   = q.bresp;
    assign S_AXI_RVALID  = q.rvalid;
    assign S_AXI_RDATA   = q.rdata;
    assign S_AXI_RRESP   = q.rresp;

    assign HORN       = q.horn_out;
    assign HORN_EN    = (q.horn != HRN_IDLE);
    assign LED        = q.led;
    assign STROBE     = q.strobe;
    assign SMOKE_STAT = q.smk_stat;
    assign BAT_STAT   = q.bat_stat;
    assign SENS_BOOST = q.smoke || (q.horn != HRN_IDLE);
    assign IRQ        = q.irq;

    always_comb begin
        d         = q;
        tick      = 1'b0;
        led_go    = 1'b0;
        irq_ev    = 3'h0;
        irq_clr   = 3'h0;
        stat_word = 32'h0;

        // One millisecond tick feeds every period counter, so switching periods
        // never truncates a pulse that is already running.
        if (q.ctrl_en) begin
            if (q.div_cnt == TICK_LIM) begin
                d.div_cnt = 20'h0;
                tick      = 1'b1;
            end else begin
                d.div_cnt = q.div_cnt + 20'h1;
            end
        end

        fast     = q.smoke || (q.horn != HRN_IDLE);
        per_lim  = fast ? FAST_LIM : SLOW_LIM;
        cyc_lim  = fast ? LEDF_LIM : BAT_LIM;
        busy     = q.led || q.chirp || (q.horn == HRN_ON);
        // The compare is >= so that a slow count beyond the fast limit wraps on the next tick.
        per_wrap = tick && (q.per_cnt >= per_lim);

        if (tick) begin
            d.per_cnt = per_wrap ? 11'h0 : q.per_cnt + 11'h1;
        end

        if (q.strobe) begin
            if (tick) begin
                if (q.str_cnt == STR_LIM) begin
                    d.strobe  = 1'b0;
                    d.str_cnt = 4'h0;
                    d.smoke   = SMOKE_CMP;
                end else begin
                    d.str_cnt = q.str_cnt + 4'h1;
                end
            end
        end else if (per_wrap && !busy) begin
            d.strobe  = 1'b1;
            d.str_cnt = 4'h0;
        end

        if (!TEST_N) begin
            d.strobe  = 1'b0;
            d.str_cnt = 4'h0;
            d.smoke   = SMOKE_CMP;
        end

        if (per_wrap) begin
            if (q.cyc_cnt >= cyc_lim) begin
                d.cyc_cnt = 5'h0;
                led_go    = 1'b1;
            end else begin
                d.cyc_cnt = q.cyc_cnt + 5'h1;
            end
        end

        // The chirp shares the LED pulse timer, both being 10 ms long.
        if (q.led) begin
            if (tick) begin
                if (q.led_cnt == LED_LIM) begin
                    d.led     = 1'b0;
                    d.chirp   = 1'b0;
                    d.led_cnt = 4'h0;
                end else begin
                    d.led_cnt = q.led_cnt + 4'h1;
                end
            end
        end else if (led_go) begin
            d.led     = 1'b1;
            d.led_cnt = 4'h0;
            d.chirp   = q.bat && !fast;
        end

        if (q.led && !fast) begin
            d.bat = BAT_CMP;
        end
        irq_ev[`SMK_IRQ_BAT] = d.bat && !q.bat;

        case (q.horn)
            HRN_IDLE: begin
                if (q.smoke) begin
                    d.horn                 = HRN_ON;
                    d.hrn_cnt              = 8'h0;
                    irq_ev[`SMK_IRQ_SMOKE] = 1'b1;
                end
            end
            HRN_ON: begin
                if (tick) begin
                    if (q.hrn_cnt == ON_LIM) begin
                        d.horn    = HRN_OFF;
                        d.hrn_cnt = 8'h0;
                    end else begin
                        d.hrn_cnt = q.hrn_cnt + 8'h1;
                    end
                end
            end
            HRN_OFF: begin
                if (tick) begin
                    if (q.hrn_cnt == OFF_LIM) begin
                        d.hrn_cnt = 8'h0;
                        if (q.smoke) begin
                            d.horn = HRN_ON;
                        end else begin
                            d.horn                 = HRN_IDLE;
                            irq_ev[`SMK_IRQ_CLEAR] = 1'b1;
                        end
                    end else begin
                        d.hrn_cnt = q.hrn_cnt + 8'h1;
                    end
                end
            end
            default: begin
                d.horn = HRN_IDLE;
            end
        endcase

        d.horn_out = (d.horn == HRN_ON) || d.chirp;
        d.smk_stat = TEST_N ? d.smoke : SMOKE_CMP;
        d.bat_stat = TEST_N ? d.bat : BAT_CMP;

        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            d.aw_v = 1'b1;
            d.aw_a = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            d.w_v = 1'b1;
            d.w_d = S_AXI_WDATA;
            d.w_s = S_AXI_WSTRB;
        end
        if (q.aw_v && q.w_v) begin
            d.aw_v   = 1'b0;
            d.w_v    = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `SMK_RESP_OKAY;
            if (q.aw_a == `SMK_OFS_CTRL) begin
                if (q.w_s[0]) begin
                    d.ctrl_en = q.w_d[0];
                end
            end else if (q.aw_a == `SMK_OFS_ISTS) begin
                if (q.w_s[0]) begin
                    irq_clr = q.w_d[2:0];
                end
            end else if (q.aw_a == `SMK_OFS_IMSK) begin
                if (q.w_s[0]) begin
                    d.irq_msk = q.w_d[2:0];
                end
            end else if (q.aw_a != `SMK_OFS_STAT) begin
                d.bresp = `SMK_RESP_SLVERR;
            end
        end
        if (q.bvalid && S_AXI_BREADY) begin
            d.bvalid = 1'b0;
        end

        // A new event wins over a clear written in the same cycle.
        d.irq_sts = (q.irq_sts & ~irq_clr) | irq_ev;
        d.irq     = |(d.irq_sts & d.irq_msk);

        stat_word[`SMK_ST_SMOKE]         = q.smoke;
        stat_word[`SMK_ST_ALARM]         = (q.horn != HRN_IDLE);
        stat_word[`SMK_ST_BAT]           = q.bat;
        stat_word[`SMK_ST_HORN]          = q.horn_out;
        stat_word[`SMK_ST_TEST]          = !TEST_N;
        stat_word[`SMK_ST_CYC +: 5]      = q.cyc_cnt;

        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            d.rvalid = 1'b1;
            d.rresp  = `SMK_RESP_OKAY;
            if (S_AXI_ARADDR == `SMK_OFS_CTRL) begin
                d.rdata = {31'h0, q.ctrl_en};
            end else if (S_AXI_ARADDR == `SMK_OFS_STAT) begin
                d.rdata = stat_word;
            end else if (S_AXI_ARADDR == `SMK_OFS_ISTS) begin
                d.rdata = {29'h0, q.irq_sts};
            end else if (S_AXI_ARADDR == `SMK_OFS_IMSK) begin
                d.rdata = {29'h0, q.irq_msk};
            end else begin
                d.rdata = 32'h0;
                d.rresp = `SMK_RESP_SLVERR;
            end
        end else if (q.rvalid && S_AXI_RREADY) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= RST_S;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    a_strobe_start: assert property (
        $rose(q.strobe) |-> $past(per_wrap) && !$past(busy))
        else $error("Strobe started off a period edge or while busy.");

    a_strobe_len: assert property (
        $fell(q.strobe) && $past(TEST_N) |-> $past(q.str_cnt) == STR_LIM && $past(tick))
        else $error("Strobe did not last its full length.");

    a_slow_period: assert property (
        per_wrap && !fast |-> q.per_cnt == SLOW_LIM)
        else $error("Slow period wrapped at the wrong count.");

    a_bat_cadence: assert property (
        per_wrap && !fast && !q.led && q.cyc_cnt == BAT_LIM |=> q.led && q.cyc_cnt == 5'h0)
        else $error("LED and battery check missed the cycle wrap.");

    a_smoke_alarm: assert property (
        q.smoke && q.horn == HRN_IDLE |=> q.horn == HRN_ON && HORN_EN && HORN)
        else $error("Smoke did not start the horn.");

    a_horn_on_len: assert property (
        q.horn == HRN_ON ##1 q.horn == HRN_OFF |-> $past(q.hrn_cnt) == ON_LIM)
        else $error("Horn on phase ended early.");

    a_alarm_end: assert property (
        q.horn == HRN_OFF ##1 q.horn == HRN_IDLE |-> !$past(q.smoke)
            && $past(q.hrn_cnt) == OFF_LIM)
        else $error("Alarm ended outside the off phase end or with smoke.");

    a_chirp_gate: assert property (
        $rose(q.chirp) |-> !$past(fast) && $past(q.bat) && $rose(q.led))
        else $error("Chirp started in smoke or without low battery.");

    a_test_follow: assert property (
        !TEST_N |=> SMOKE_STAT == $past(SMOKE_CMP) && BAT_STAT == $past(BAT_CMP) && !STROBE)
        else $error("Test mode outputs do not follow the comparators.");

    a_bat_hold: assert property (
        !q.led |=> $stable(q.bat))
        else $error("Battery state changed outside the LED pulse.");

    a_boost_on: assert property (
        $rose(q.smoke) |-> SENS_BOOST ##1 SENS_BOOST)
        else $error("Sensitivity boost not raised with smoke.");

endmodule

//--- rtl/smkseq_params.svh
// Purpose: Constants of the smoke alarm sequencer: timing, limits, register map.
// Assumes: A 125 MHz core clock; all slow periods are built from a 1 ms tick.
// Notes: Times are kept in their own unit; cycle and tick counts derive from them.
`ifndef SMKSEQ_PARAMS_SVH
`define SMKSEQ_PARAMS_SVH

`define SMK_CLK_MHZ          125
`define SMK_TICK_NS          1000000
`define SMK_TICK_CYC         ((`SMK_TICK_NS * `SMK_CLK_MHZ) / 1000)
`define SMK_TICK_MS          1

`define SMK_SLOW_MS          1670
`define SMK_FAST_MS          40
`define SMK_HORN_ON_MS       160
`define SMK_HORN_OFF_MS      80
`define SMK_STROBE_MS        10
`define SMK_LED_MS           10
`define SMK_BAT_CYCLES       24
`define SMK_LED_FAST_CYCLES  25

`define SMK_OFS_CTRL         8'h00
`define SMK_OFS_STAT         8'h04
`define SMK_OFS_ISTS         8'h08
`define SMK_OFS_IMSK         8'h0c

`define SMK_CTRL_RST         1'h1
`define SMK_IMSK_RST         3'h0

`define SMK_ST_SMOKE         0
`define SMK_ST_ALARM         1
`define SMK_ST_BAT           2
`define SMK_ST_HORN          3
`define SMK_ST_TEST          4
`define SMK_ST_CYC           8

`define SMK_IRQ_SMOKE        0
`define SMK_IRQ_BAT          1
`define SMK_IRQ_CLEAR        2

`define SMK_RESP_OKAY        2'h0
`define SMK_RESP_SLVERR      2'h2

`endif

//--- rtl/smkseq_pkg.sv
// Purpose: Types of the smoke alarm sequencer.
// Assumes: Constants come from smkseq_params.svh.
// Notes: The whole state of the top module is one packed struct.
package smkseq_pkg;

    typedef enum logic [1:0] {
        HRN_IDLE = 2'b00,
        HRN_ON   = 2'b01,
        HRN_OFF  = 2'b10
    } smkseq_horn_t;

    typedef struct packed {
        logic [19:0]  div_cnt;
        logic [10:0]  per_cnt;
        logic [4:0]   cyc_cnt;
        logic         strobe;
        logic [3:0]   str_cnt;
        logic         led;
        logic [3:0]   led_cnt;
        logic         chirp;
        smkseq_horn_t horn;
        logic [7:0]   hrn_cnt;
        logic         smoke;
        logic         bat;
        logic         smk_stat;
        logic         bat_stat;
        logic         horn_out;
        logic         ctrl_en;
        logic [2:0]   irq_sts;
        logic [2:0]   irq_msk;
        logic         irq;
        logic         aw_v;
        logic [7:0]   aw_a;
        logic         w_v;
        logic [31:0]  w_d;
        logic [3:0]   w_s;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } smkseq_state_t;

endpackage

//--- dv/smkseq_cmp_model.sv
// Purpose: Far-side model of the smoke and battery comparators.
// Assumes: A comparator is powered only by a strobe, the LED load or test mode.
// Notes: An unpowered comparator gives a changing pattern, never its last value.
`timescale 1ns/1ps
module smkseq_cmp_model (
    input  wire logic clk,
    input  wire logic strobe,
    input  wire logic led,
    input  wire logic test_n,
    input  wire logic smoke_lvl,
    input  wire logic bat_lvl,
    output wire logic smoke_cmp,
    output wire logic bat_cmp
);
    logic junk_q = 1'b0;

    always_ff @(posedge clk) begin
        junk_q <= ~junk_q;
    end

    assign smoke_cmp = (strobe | ~test_n) ? smoke_lvl : junk_q;
    assign bat_cmp   = (led | ~test_n) ? bat_lvl : ~junk_q;
endmodule

//--- dv/tb_smoke_alarm_sequencer.sv
// Purpose: Self-checking bench of the smoke alarm sequencer.
// Assumes: TICK_CYC is cut to 4 clocks so that every period stays short.
// Notes: Outputs are read at an edge before that edge updates them, so counts are whole clocks.
`timescale 1ns/1ps
`include "smkseq_params.svh"
module tb_smoke_alarm_sequencer;
    localparam int TK    = 4;
    localparam int SLOW  = `SMK_SLOW_MS * TK;
    localparam int STB   = `SMK_STROBE_MS * TK;
    localparam int HON   = `SMK_HORN_ON_MS * TK;
    localparam int HOFF  = `SMK_HORN_OFF_MS * TK;
    localparam int LEDW  = `SMK_LED_MS * TK;
    localparam int LEDP  = `SMK_LED_FAST_CYCLES * `SMK_FAST_MS * TK;
    localparam int LIMIT = 60000;
    logic             clk = 1'b0, rst_n = 1'b0, test_n = 1'b1, smoke_lvl = 1'b0, bat_lvl = 1'b0;
    logic             awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic             strobe_q = 1'b0, horn_q = 1'b0, led_q = 1'b0;
    logic [7:0]       awa = 8'h00, ara = 8'h00;
    logic [31:0]      wd = 32'h0, v;
    logic [1:0]       rsp;
    wire logic        smoke_cmp, bat_cmp, horn, horn_en, led, strobe, smoke_stat, bat_stat;
    wire logic        sens, irq, awr, wr, bv, arr, rv;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rd;
    wire logic [7:0]  obs = {irq, sens, bat_stat, smoke_stat, strobe, led, horn_en, horn};
    int               bad_count = 0, n_compared = 0, cyc = 0, n_str = 0, n_horn = 0, n, m;

    always #4 clk = ~clk;

    smkseq_top #(.TICK_CYC(TK)) dut (
        .CORE_CLK(clk), .RST_N(rst_n), .SMOKE_CMP(smoke_cmp), .BAT_CMP(bat_cmp),
        .TEST_N(test_n), .HORN(horn), .HORN_EN(horn_en), .LED(led), .STROBE(strobe),
        .SMOKE_STAT(smoke_stat), .BAT_STAT(bat_stat), .SENS_BOOST(sens), .IRQ(irq),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(br), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rd),
        .S_AXI_RRESP(rresp));

    smkseq_cmp_model model (
        .clk(clk), .strobe(strobe), .led(led), .test_n(test_n), .smoke_lvl(smoke_lvl),
        .bat_lvl(bat_lvl), .smoke_cmp(smoke_cmp), .bat_cmp(bat_cmp));

    task automatic conclude();
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_n(input string nm, input int e, input int g);
        n_compared++;
        if (g != e) begin
            bad_count++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        r = bresp;
        br <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e,
                          input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        chk("read data", e, rd & msk);
        chk("read resp", {30'h0, er}, {30'h0, rresp});
        rr <= 1'b0;
    endtask

    // Waits until output bit i shows level l and returns the clocks spent.
    task automatic wait_lvl(input int i, input logic l, output int k);
        k = 0;
        while (obs[i] !== l) begin
            @(posedge clk);
            k++;
        end
    endtask

    always @(posedge clk) begin
        strobe_q <= strobe;
        horn_q <= horn;
        led_q <= led;
        cyc <= cyc + 1;
        if (strobe === 1'b1 && strobe_q === 1'b0) begin
            n_str <= n_str + 1;
            chk("strobe in busy phase", 32'h0, {31'h0, (horn_q & horn) | (led_q & led)});
        end
        if (horn === 1'b1 && horn_q === 1'b0) n_horn <= n_horn + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        void'($urandom(70550));
        repeat (10) @(posedge clk);
        chk("reset outputs", 32'h0, {24'h0, obs});
        chk("reset awready", 32'h1, {31'h0, awr});
        rst_n <= 1'b1;
        rd_chk(`SMK_OFS_CTRL, 32'hffffffff, 32'h1, `SMK_RESP_OKAY);
        rd_chk(`SMK_OFS_IMSK, 32'hffffffff, 32'h0, `SMK_RESP_OKAY);
        rd_chk(8'h10, 32'hffffffff, 32'h0, `SMK_RESP_SLVERR);
        axi_wr(8'h14, 32'h1, rsp);
        chk("unmapped write resp", {30'h0, `SMK_RESP_SLVERR}, {30'h0, rsp});
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            axi_wr(`SMK_OFS_IMSK, v, rsp);
            rd_chk(`SMK_OFS_IMSK, 32'hffffffff, {29'h0, v[2:0]}, `SMK_RESP_OKAY);
        end
        axi_wr(`SMK_OFS_IMSK, 32'h5, rsp);
        wait_lvl(3, 1, n);
        wait_lvl(3, 0, n);
        chk_n("strobe width", STB, n);
        wait_lvl(3, 1, m);
        chk_n("slow period", SLOW, n + m);
        smoke_lvl <= 1'b1;
        wait_lvl(3, 0, n);
        wait_lvl(0, 1, n);
        chk_n("horn start delay", 1, n);
        chk("alarm start pins", 32'h53, {24'h0, obs & 8'h7b});
        wait_lvl(0, 0, n);
        // The first on phase starts one clock after the tick that raised the smoke flag,
        // so it ends one clock short of a whole number of ticks.
        chk_n("horn on", HON - 1, n);
        chk("irq on alarm", 32'h1, {31'h0, irq});
        rd_chk(`SMK_OFS_STAT, 32'h3, 32'h3, `SMK_RESP_OKAY);
        rd_chk(`SMK_OFS_ISTS, 32'h7, 32'h1, `SMK_RESP_OKAY);
        axi_wr(`SMK_OFS_ISTS, 32'h1, rsp);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wait_lvl(0, 1, n);
        wait_lvl(0, 0, n);
        wait_lvl(0, 1, n);
        chk_n("horn off", HOFF, n);
        bat_lvl <= 1'b1;
        wait_lvl(2, 0, n);
        wait_lvl(2, 1, n);
        wait_lvl(2, 0, n);
        chk_n("led width", LEDW, n);
        wait_lvl(2, 1, m);
        chk_n("led period in smoke", LEDP, n + m);
        chk("battery held in smoke", 32'h0, {31'h0, bat_stat});
        wait_lvl(0, 0, n);
        wait_lvl(0, 1, n);
        smoke_lvl <= 1'b0;
        wait_lvl(0, 0, n);
        chk_n("last on phase", HON, n);
        wait_lvl(1, 0, n);
        chk("end window", 32'h1, {31'h0, n >= HOFF - 1 && n <= HOFF + 1});
        chk("alarm end pins", 32'h0, {24'h0, obs & 8'h53});
        repeat (2) @(posedge clk);
        chk("irq on alarm end", 32'h1, {31'h0, irq});
        axi_wr(`SMK_OFS_IMSK, 32'h0, rsp);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk(`SMK_OFS_ISTS, 32'h7, 32'h4, `SMK_RESP_OKAY);
        axi_wr(`SMK_OFS_ISTS, 32'h7, rsp);
        rd_chk(`SMK_OFS_ISTS, 32'h7, 32'h0, `SMK_RESP_OKAY);
        // The window below outlasts one slow period, so a missed bypass shows as a strobe.
        m = n_str;
        n = n_horn;
        test_n <= 1'b0;
        for (int i = 0; i < 50; i++) begin
            bat_lvl <= 1'($urandom % 2);
            repeat (140 + $urandom % 20) @(posedge clk);
            chk("battery follows", {31'h0, bat_lvl}, {31'h0, bat_stat});
        end
        chk_n("strobes in test mode", m, n_str);
        chk_n("horn after alarm end", n, n_horn);
        smoke_lvl <= 1'b1;
        repeat (3) @(posedge clk);
        chk("smoke follows", 32'h1, {31'h0, smoke_stat});
        conclude();
    end
endmodule
